// ==== aatr_adc_model.sv ====
// adc core model: ends each requested touch slot after lat cycles
// assumes touchSlot_q holds until the slot is answered
`timescale 1ns/1ns
module aatr_adc_model (
   input wire clk_sys, // clock
   input wire rst_b, // reset, low
   input wire [3:0] touchSlot_q, // slot request
   output reg slotDone // one-cycle slot end
);
   integer lat = 3; // slot length, raise for a slow core
   integer cnt;
   reg [3:0] seen;
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cnt <= 0;
         seen <= 4'h0;
         slotDone <= 1'b0;
      end else begin
         slotDone <= 1'b0;
         if (touchSlot_q != seen) begin
            seen <= touchSlot_q;
            cnt <= 0;
         end else if (seen != 4'h0 && cnt < lat) begin
            cnt <= cnt + 1;
            slotDone <= (cnt == lat - 1);
         end
      end
   end
endmodule // aatr_adc_model

// ==== aatr_interval_timer.v ====
// sequence interval timer: pulses once per economy or fast interval
// assumes a free running clk_sys; counts are parameters for short simulation
`timescale 1ns/1ns
`include "aatr_map.vh"
module aatr_interval_timer #(
   parameter [23:0] ECO_CYCLES = 24'd1250000,
   parameter [23:0] FAST_CYCLES = 24'd125000
) (
   input wire clk_sys, // system clock
   input wire rst_b, // async reset, active low
   input wire fastMode, // 1 selects the short interval
   output reg tick_q // one-cycle interval pulse
);
   reg [23:0] count_q;
   wire [23:0] limit = fastMode ? FAST_CYCLES : ECO_CYCLES;
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         count_q <= 24'h00_0000;
         tick_q <= 1'b0;
      end else if (count_q + 24'h00_0001 >= limit) begin // [R18]
         count_q <= 24'h00_0000;
         tick_q <= 1'b1;
      end else begin
         count_q <= count_q + 24'h00_0001;
         tick_q <= 1'b0;
      end
   end
endmodule // aatr_interval_timer

// ==== aatr_map.vh ====
// register map, field positions, reset values and timing for the auto adc register bank
// assumes inclusion by bare name from the design files
`ifndef AATR_MAP_VH
`define AATR_MAP_VH
`define AATR_ADDR_W 8
`define AATR_DATA_W 8
`define AATR_OFF_BATT_LOW 8'h5d
`define AATR_OFF_TCAL 8'h5e
`define AATR_OFF_CH4_RES 8'h5f
`define AATR_OFF_CH4_HI 8'h60
`define AATR_OFF_CH4_LO 8'h61
`define AATR_OFF_CH5_RES 8'h62
`define AATR_OFF_CH5_HI 8'h63
`define AATR_OFF_CH5_LO 8'h64
`define AATR_OFF_CH6_RES 8'h65
`define AATR_OFF_CH6_HI 8'h66
`define AATR_OFF_CH6_LO 8'h67
`define AATR_OFF_TJ_RES 8'h68
`define AATR_OFF_TCTL_A 8'h69
`define AATR_OFF_AUTO_CTL 8'h70
`define AATR_OFF_EVENT 8'h71
`define AATR_OFF_STATUS 8'h72
`define AATR_RST_ONES 8'h00ff
`define AATR_RST_ZERO 8'h0000
`define AATR_BIT_AUTO_EN 0
`define AATR_BIT_PEN_EN 1
`define AATR_BIT_XONLY 2
`define AATR_BIT_CH4_EN 0
`define AATR_BIT_CH5_EN 1
`define AATR_BIT_CH6_EN 2
`define AATR_BIT_FAST 3
`define AATR_SLOT_W 4
`define AATR_SLOT_X 4'h1
`define AATR_SLOT_Y 4'h2
`define AATR_SLOT_Z 4'h4
`define AATR_SLOT_PEN 4'h8
`define AATR_ECO_INTERVAL_MS 10
`define AATR_FAST_INTERVAL_MS 1
`define AATR_CLK_KHZ 125000
`define AATR_NUM_CH 3
`endif

// ==== aatr_regs.v ====
// What this block does
// R1 - battery temperature low threshold, read-write, resets to all ones
// R2 - junction temperature calibration offset, signed, read-write, resets to zero
// R3 - channel four auto result, read-only, resets to zero
// R4 - channel four high threshold, read-write, resets to all ones
// R5 - channel four low threshold, read-write, resets to zero
// R6 - channel five auto result, read-only, resets to zero
// R7 - channel five high threshold, read-write, resets to all ones
// R8 - channel five low threshold, read-write, resets to zero
// R9 - channel six auto result, read-only, resets to zero
// R10 - channel six high threshold, read-write, resets to all ones
// R11 - channel six low threshold, read-write, resets to zero
// R12 - junction temperature result from internal channel, read-only, resets to zero
// R13 - auto enable bit gates every automatic touch sequence
// R14 - pen enable bit turns on pen detect and repeats
// R15 - mode zero measures x, y, z, x, y each with pen check
// R16 - mode one measures x only with pen check
// R17 - with pen enable repeat until pen lifts, else one sequence
// R18 - sequence interval ten ms economy, one ms fast
// R19 - flag result above high or below low when channel enabled
// R20 - result registers update whole at end of conversion slot
//
// register bank for automatic adc results, thresholds and touch control
// assumes a plain strobe bus on clk_sys and adc core results with done strobes
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ns
`include "aatr_map.vh"
module aatr_regs #(
   parameter [23:0] ECO_CYCLES = `AATR_ECO_INTERVAL_MS * `AATR_CLK_KHZ,
   parameter [23:0] FAST_CYCLES = `AATR_FAST_INTERVAL_MS * `AATR_CLK_KHZ
) (
   input wire clk_sys, // system clock 125 MHz
   input wire rst_b, // async reset, active low
   input wire [7:0] regAddr, // register address
   input wire [7:0] regWrData, // write data
   input wire regWrStb, // write strobe
   input wire regRdStb, // read strobe
   output reg [7:0] regRdData_q, // read data, cycle after strobe
   input wire [23:0] chanResults, // ch6,ch5,ch4 conversion values
   input wire [2:0] chanDone, // per channel conversion done pulse
   input wire [7:0] junctionResult, // internal channel conversion value
   input wire junctionDone, // junction conversion done pulse
   input wire penDownPin, // pen down level from comparator
   input wire slotDone, // adc slot finished pulse
   input wire manualTrigger, // manual measurement pulse
   output reg [3:0] touchSlot_q, // one-hot touch slot request
   output reg touchBusy_q, // touch sequence running
   output reg [7:0] tempOffset_q, // calibration offset to the adc core
   output reg [7:0] battLowThreshold_q, // battery temperature low threshold
   output reg intervalTick_q // start of each auto sequence interval
);
   reg [7:0] tctlA_q;
   reg [7:0] autoCtl_q;
   reg [7:0] tjRes_q;
   wire [2:0] evHigh;
   wire [2:0] evLow;
   reg [2:0] penSync_q;
   reg penLevel_q;
   wire [23:0] resFlat;
   wire [23:0] hiFlat;
   wire [23:0] loFlat;
   wire tick;
   wire [3:0] seqSlot;
   wire seqBusy;
   wire wrEvent = regWrStb && (regAddr == `AATR_OFF_EVENT);
   // ************************************************************
   // per channel result, thresholds, events
   // ************************************************************
   genvar gi;
   generate
      for (gi = 0; gi < `AATR_NUM_CH; gi = gi + 1) begin : gCh
         reg [7:0] res_q;
         reg [7:0] hi_q;
         reg [7:0] lo_q;
         reg evHi_q;
         reg evLo_q;
         wire [31:0] offSum = `AATR_OFF_CH4_RES + 8'd3 * gi;
         wire [7:0] offRes = offSum[7:0];
         wire en = autoCtl_q[gi];
         wire [7:0] newVal = chanResults[8*gi +: 8];
         always @(posedge clk_sys or negedge rst_b) begin
            if (!rst_b) begin
               res_q <= `AATR_RST_ZERO; // [R3] [R6] [R9]
               hi_q <= `AATR_RST_ONES; // [R4] [R7] [R10]
               lo_q <= `AATR_RST_ZERO; // [R5] [R8] [R11]
               evHi_q <= 1'b0;
               evLo_q <= 1'b0;
            end else begin
               if (chanDone[gi] && en) begin
                  res_q <= newVal; // [R20]
               end
               if (regWrStb && regAddr == offRes + 8'd1) begin
                  hi_q <= regWrData;
               end
               if (regWrStb && regAddr == offRes + 8'd2) begin
                  lo_q <= regWrData;
               end
               // set wins over clear
               if (chanDone[gi] && en && newVal > hi_q) begin
                  evHi_q <= 1'b1; // [R19]
               end else if (wrEvent && regWrData[gi]) begin
                  evHi_q <= 1'b0;
               end
               if (chanDone[gi] && en && newVal < lo_q) begin
                  evLo_q <= 1'b1; // [R19]
               end else if (wrEvent && regWrData[gi + 4]) begin
                  evLo_q <= 1'b0;
               end
            end
         end
         assign resFlat[8*gi +: 8] = res_q;
         assign hiFlat[8*gi +: 8] = hi_q;
         assign loFlat[8*gi +: 8] = lo_q;
         assign evHigh[gi] = evHi_q;
         assign evLow[gi] = evLo_q;
      end
   endgenerate
   // ************************************************************
   // plain registers and pen synchroniser
   // ************************************************************
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         tctlA_q <= `AATR_RST_ZERO;
         autoCtl_q <= `AATR_RST_ZERO;
         tempOffset_q <= `AATR_RST_ZERO; // [R2]
         battLowThreshold_q <= `AATR_RST_ONES; // [R1]
         tjRes_q <= `AATR_RST_ZERO; // [R12]
         penSync_q <= 3'b000;
         penLevel_q <= 1'b0;
      end else begin
         penSync_q <= {penSync_q[1:0], penDownPin};
         if (penSync_q[2] == penSync_q[1]) begin
            penLevel_q <= penSync_q[2];
         end
         if (junctionDone) begin
            tjRes_q <= junctionResult; // [R12] [R20]
         end
         if (regWrStb) begin
            case (regAddr)
               `AATR_OFF_BATT_LOW: battLowThreshold_q <= regWrData; // [R1]
               `AATR_OFF_TCAL: tempOffset_q <= regWrData; // [R2]
               `AATR_OFF_TCTL_A: tctlA_q <= regWrData;
               `AATR_OFF_AUTO_CTL: autoCtl_q <= regWrData;
               default: tctlA_q <= tctlA_q;
            endcase
         end
      end
   end
   // ************************************************************
   // read path
   // ************************************************************
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         regRdData_q <= `AATR_RST_ZERO;
      end else if (regRdStb) begin
         case (regAddr)
            `AATR_OFF_BATT_LOW: regRdData_q <= battLowThreshold_q;
            `AATR_OFF_TCAL: regRdData_q <= tempOffset_q;
            `AATR_OFF_CH4_RES: regRdData_q <= resFlat[7:0];
            `AATR_OFF_CH4_HI: regRdData_q <= hiFlat[7:0];
            `AATR_OFF_CH4_LO: regRdData_q <= loFlat[7:0];
            `AATR_OFF_CH5_RES: regRdData_q <= resFlat[15:8];
            `AATR_OFF_CH5_HI: regRdData_q <= hiFlat[15:8];
            `AATR_OFF_CH5_LO: regRdData_q <= loFlat[15:8];
            `AATR_OFF_CH6_RES: regRdData_q <= resFlat[23:16];
            `AATR_OFF_CH6_HI: regRdData_q <= hiFlat[23:16];
            `AATR_OFF_CH6_LO: regRdData_q <= loFlat[23:16];
            `AATR_OFF_TJ_RES: regRdData_q <= tjRes_q;
            `AATR_OFF_TCTL_A: regRdData_q <= tctlA_q;
            `AATR_OFF_AUTO_CTL: regRdData_q <= autoCtl_q;
            `AATR_OFF_EVENT: regRdData_q <= {1'b0, evLow, 1'b0, evHigh};
            `AATR_OFF_STATUS: regRdData_q <= {2'b00, penLevel_q, touchBusy_q, touchSlot_q};
            default: regRdData_q <= `AATR_RST_ZERO;
         endcase
      end
   end
   // ************************************************************
   // sequencing
   // ************************************************************
   aatr_interval_timer #(
      .ECO_CYCLES(ECO_CYCLES),
      .FAST_CYCLES(FAST_CYCLES)
   ) uTimer (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .fastMode(autoCtl_q[`AATR_BIT_FAST]), // [R18]
      .tick_q(tick)
   );
   aatr_touch_seq uSeq (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .autoEnable(tctlA_q[`AATR_BIT_AUTO_EN]), // [R13]
      .penEnable(tctlA_q[`AATR_BIT_PEN_EN]), // [R14]
      .xOnly(tctlA_q[`AATR_BIT_XONLY]), // [R16]
      .trigger(manualTrigger),
      .penDown(penLevel_q),
      .slotDone(slotDone),
      .slot_q(seqSlot),
      .busy_q(seqBusy)
   );
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         touchSlot_q <= 4'h0;
         touchBusy_q <= 1'b0;
         intervalTick_q <= 1'b0;
      end else begin
         touchSlot_q <= seqSlot;
         touchBusy_q <= seqBusy;
         intervalTick_q <= tick;
      end
   end
endmodule // aatr_regs

// ==== aatr_regs_chk.sv ====
// checker: register mirrors, read path and touch slot order of aatr_regs
// assumes only the top ports of aatr_regs, bound at the foot of this file
`timescale 1ns/1ns
module aatr_regs_chk (
   input wire clk_sys, // clock
   input wire rst_b, // reset, low
   input wire [7:0] regAddr, // address
   input wire [7:0] regWrData, // write data
   input wire regWrStb, // write strobe
   input wire regRdStb, // read strobe
   input wire [7:0] regRdData_q, // read data
   input wire [23:0] chanResults, // results
   input wire [2:0] chanDone, // done pulses
   input wire [7:0] junctionResult, // junction value
   input wire junctionDone, // junction done
   input wire penDownPin, // pen level
   input wire slotDone, // slot done
   input wire manualTrigger, // manual start
   input wire [3:0] touchSlot_q, // slot
   input wire touchBusy_q, // busy
   input wire [7:0] tempOffset_q, // offset out
   input wire [7:0] battLowThreshold_q, // threshold out
   input wire intervalTick_q // interval pulse
);
   reg autoEn_q; // shadow of the auto enable bit
   reg xOnly_q; // shadow of the x only select
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         autoEn_q <= 1'b0;
         xOnly_q <= 1'b0;
      end else if (regWrStb && regAddr == 8'h69) begin
         autoEn_q <= regWrData[0];
         xOnly_q <= regWrData[2];
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   a_batt_mirror: assert property (regWrStb && regAddr == 8'h5d
      |=> battLowThreshold_q == $past(regWrData)) else $error("battery threshold missed a write");
   a_tcal_mirror: assert property (regWrStb && regAddr == 8'h5e
      |=> tempOffset_q == $past(regWrData)) else $error("offset output missed a write");
   a_batt_readback: assert property (regRdStb && regAddr == 8'h5d
      |=> regRdData_q == battLowThreshold_q) else $error("threshold read back wrong");
   a_slot_onehot: assert property ($onehot0(touchSlot_q))
      else $error("touch slot not one-hot");
   a_pen_follows: assert property (autoEn_q && slotDone && touchSlot_q inside {4'h1, 4'h2, 4'h4}
      |-> ##[1:2] touchSlot_q == 4'h8) else $error("measurement not followed by pen check");
   a_xonly_slots: assert property (autoEn_q && xOnly_q |-> touchSlot_q[2:1] == 2'b00)
      else $error("y or z slot in x only mode");
   a_manual_start: assert property (autoEn_q && !touchBusy_q && manualTrigger
      |-> ##[1:2] touchSlot_q == 4'h1) else $error("manual trigger did not start x slot");
   a_auto_gate: assert property (!autoEn_q [*3] |-> touchSlot_q == 4'h0 && !touchBusy_q)
      else $error("touch sequence while auto disabled");
endmodule // aatr_regs_chk
bind aatr_regs aatr_regs_chk aatr_regs_chk_inst (.clk_sys(clk_sys), .rst_b(rst_b),
   .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
   .regRdData_q(regRdData_q), .chanResults(chanResults), .chanDone(chanDone),
   .junctionResult(junctionResult), .junctionDone(junctionDone), .penDownPin(penDownPin),
   .slotDone(slotDone), .manualTrigger(manualTrigger), .touchSlot_q(touchSlot_q),
   .touchBusy_q(touchBusy_q), .tempOffset_q(tempOffset_q),
   .battLowThreshold_q(battLowThreshold_q), .intervalTick_q(intervalTick_q));

// ==== aatr_touch_seq.v ====
// touch sequence engine: steps through measurement slots, each followed by a pen check
// assumes pen level already synchronised; one slot per slotDone pulse
`timescale 1ns/1ns
`include "aatr_map.vh"
module aatr_touch_seq (
   input wire clk_sys, // system clock
   input wire rst_b, // async reset, active low
   input wire autoEnable, // automatic sequences allowed
   input wire penEnable, // pen detect and repeat allowed
   input wire xOnly, // 1 selects x only sequence
   input wire trigger, // start pulse, driven from manualTrigger only
   input wire penDown, // synchronised pen level
   input wire slotDone, // current slot finished
   output reg [3:0] slot_q, // one-hot slot being measured, zero when idle
   output reg busy_q // sequence running
);
   localparam S_IDLE = 3'b001;
   localparam S_MEAS = 3'b010;
   localparam S_PEN = 3'b100;
   reg [2:0] state_q;
   reg [2:0] step_q;
   reg [3:0] measSlot;
   // slot for the step about to start, not the one just ended
   wire [2:0] nextStep = step_q + 3'd1;
   wire lastStep = xOnly ? (step_q == 3'd0) : (step_q == 3'd4);
   // xyz then two more x,y
   always @* begin
      case (nextStep)
         3'd0: measSlot = `AATR_SLOT_X;
         3'd1: measSlot = xOnly ? `AATR_SLOT_X : `AATR_SLOT_Y;
         3'd2: measSlot = `AATR_SLOT_Z;
         3'd3: measSlot = `AATR_SLOT_X;
         default: measSlot = `AATR_SLOT_Y;
      endcase
   end
   wire penTrig = penEnable & penDown;
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= S_IDLE;
         step_q <= 3'd0;
         slot_q <= 4'h0;
         busy_q <= 1'b0;
      end else begin
         case (state_q)
            S_IDLE: begin
               if (autoEnable && (trigger || penTrig)) begin // [R13]
                  state_q <= S_MEAS;
                  step_q <= 3'd0;
                  slot_q <= `AATR_SLOT_X;
                  busy_q <= 1'b1;
               end else begin
                  slot_q <= 4'h0;
                  busy_q <= 1'b0;
               end
            end
            S_MEAS: begin
               if (!autoEnable) begin
                  state_q <= S_IDLE;
                  slot_q <= 4'h0;
               end else if (slotDone) begin
                  state_q <= S_PEN; // [R15] [R16]
                  slot_q <= `AATR_SLOT_PEN;
               end
            end
            S_PEN: begin
               if (!autoEnable) begin
                  state_q <= S_IDLE;
                  slot_q <= 4'h0;
               end else if (slotDone) begin
                  if (!lastStep) begin
                     step_q <= step_q + 3'd1;
                     state_q <= S_MEAS;
                     slot_q <= measSlot;
                  end else if (penEnable && penDown) begin // [R17] [R14]
                     step_q <= 3'd0;
                     state_q <= S_MEAS;
                     slot_q <= `AATR_SLOT_X;
                  end else begin
                     state_q <= S_IDLE;
                     slot_q <= 4'h0;
                  end
               end
            end
            default: begin
               state_q <= S_IDLE;
               slot_q <= 4'h0;
            end
         endcase
      end
   end
endmodule // aatr_touch_seq

// ==== adc_auto_threshold_tsi_regs_tb_top.sv ====
// testbench: register map, results, thresholds, touch sequences, interval
// assumes aatr_regs with short interval counts and the adc core model
`timescale 1ns/1ns
module adc_auto_threshold_tsi_regs_tb_top;
   reg clk_sys = 1'b0, rst_b = 1'b0, regWrStb = 1'b0, regRdStb = 1'b0;
   reg penDownPin = 1'b0, manualTrigger = 1'b0, junctionDone = 1'b0;
   reg [7:0] regAddr = 8'h00, regWrData = 8'h00, junctionResult = 8'h00, rdv;
   reg [23:0] chanResults = 24'h0000;
   reg [2:0] chanDone = 3'h0;
   wire [7:0] regRdData_q, tempOffset_q, battLowThreshold_q;
   wire [3:0] touchSlot_q;
   wire slotDone, touchBusy_q, intervalTick_q;
   integer errors = 0, compares = 0, g;
   always #4 clk_sys = ~clk_sys;
   aatr_regs #(.ECO_CYCLES(24'h0014), .FAST_CYCLES(24'h0005)) aatr_regs_inst (
      .clk_sys(clk_sys), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
      .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData_q(regRdData_q),
      .chanResults(chanResults), .chanDone(chanDone), .junctionResult(junctionResult),
      .junctionDone(junctionDone), .penDownPin(penDownPin), .slotDone(slotDone),
      .manualTrigger(manualTrigger), .touchSlot_q(touchSlot_q), .touchBusy_q(touchBusy_q),
      .tempOffset_q(tempOffset_q), .battLowThreshold_q(battLowThreshold_q),
      .intervalTick_q(intervalTick_q));
   aatr_adc_model aatr_adc_model_inst (.clk_sys(clk_sys), .rst_b(rst_b),
      .touchSlot_q(touchSlot_q), .slotDone(slotDone));
   task complete_run;
      begin
         $display("compares %0d errors %0d", compares, errors);
         if (errors == 0 && compares > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   task chk(input [95:0] nm, input [7:0] id, input [7:0] e, input [7:0] got);
      begin
         compares = compares + 1;
         if (got !== e) begin
            errors = errors + 1;
            $display("[ERR] %0s %h expected %h seen %h", nm, id, e, got);
         end
      end
   endtask
   task wr(input [7:0] a, input [7:0] d);
      begin
         @(posedge clk_sys);
         regAddr <= a;
         regWrData <= d;
         regWrStb <= 1'b1;
         @(posedge clk_sys);
         regWrStb <= 1'b0;
         #1;
      end
   endtask
   task rdc(input [7:0] a, input [7:0] e);
      begin
         @(posedge clk_sys);
         regAddr <= a;
         regRdStb <= 1'b1;
         @(posedge clk_sys);
         regRdStb <= 1'b0;
         @(negedge clk_sys);
         chk("register", a, e, regRdData_q);
      end
   endtask
   task convert(input [23:0] v, input [7:0] j);
      begin
         @(posedge clk_sys);
         chanResults <= v;
         chanDone <= 3'h7;
         junctionResult <= j;
         junctionDone <= 1'b1;
         @(posedge clk_sys);
         chanResults <= ~v;
         chanDone <= 3'h0;
         junctionResult <= ~j;
         junctionDone <= 1'b0;
      end
   endtask
   task t_regs;
      integer i;
      begin
         for (i = 0; i < 13; i = i + 1)
            rdc(8'h5d + i[7:0], (i % 3 == 0 && i < 12) ? 8'hff : 8'h00);
         for (i = 0; i < 13; i = i + 1) begin
            wr(8'h5d + i[7:0], 8'ha5 ^ i[7:0]);
            rdc(8'h5d + i[7:0], (i % 3 == 2 && i < 12) ? 8'h00 : 8'ha5 ^ i[7:0]);
         end
         chk("battout", 8'h5d, 8'ha5, battLowThreshold_q);
         wr(8'h5e, 8'h80);
         chk("offset", 8'h5e, 8'h80, tempOffset_q);
         wr(8'h5e, 8'h7f);
         chk("offset", 8'h5e, 8'h7f, tempOffset_q);
         rdc(8'h80, 8'h00);
         $display("test registers done");
      end
   endtask
   task t_results;
      begin
         wr(8'h60, 8'h40);
         wr(8'h61, 8'h00);
         wr(8'h63, 8'hff);
         wr(8'h64, 8'h20);
         wr(8'h66, 8'hff);
         wr(8'h67, 8'h00);
         convert(24'h80_1041, 8'h3c);
         rdc(8'h5f, 8'h00);
         rdc(8'h68, 8'h3c);
         wr(8'h70, 8'h07);
         convert(24'h80_1041, 8'h3d);
         rdc(8'h5f, 8'h41);
         rdc(8'h62, 8'h10);
         rdc(8'h65, 8'h80);
         rdc(8'h68, 8'h3d);
         rdc(8'h71, 8'h21);
         wr(8'h71, 8'h21);
         rdc(8'h71, 8'h00);
         rdc(8'h72, 8'h00);
         $display("test results done");
      end
   endtask
   task seq(input [7:0] ctl, input [39:0] exp, input integer n);
      integer k, t;
      reg [3:0] last;
      begin
         wr(8'h69, ctl);
         @(posedge clk_sys);
         manualTrigger <= 1'b1;
         @(posedge clk_sys);
         manualTrigger <= 1'b0;
         last = 4'h0;
         k = 0;
         for (t = 0; t < 300; t = t + 1) begin
            @(negedge clk_sys);
            if (touchSlot_q !== last && touchSlot_q !== 4'h0) begin
               if (k < n)
                  chk("slot", k[7:0], {4'h0, exp[39-4*k -: 4]}, {4'h0, touchSlot_q});
               k = k + 1;
            end
            last = touchSlot_q;
         end
         chk("slotcount", ctl, n[7:0], k[7:0]);
         chk("busy", ctl, 8'h00, {7'h00, touchBusy_q});
         $display("test sequence %h done", ctl);
      end
   endtask
   task t_pen;
      integer t, k;
      begin
         wr(8'h69, 8'h07);
         @(posedge clk_sys);
         penDownPin <= 1'b1;
         k = 0;
         for (t = 0; t < 300; t = t + 1) begin
            @(negedge clk_sys);
            if (touchSlot_q === 4'h1 && slotDone === 1'b1)
               k = k + 1;
         end
         chk("repeats", 8'h07, 8'h01, {7'h00, k >= 3});
         @(posedge clk_sys);
         penDownPin <= 1'b0;
         repeat (100) @(posedge clk_sys);
         chk("penup", 8'h07, 8'h00, {7'h00, touchBusy_q});
         wr(8'h69, 8'h05);
         @(posedge clk_sys);
         penDownPin <= 1'b1;
         repeat (60) @(posedge clk_sys);
         chk("pendis", 8'h05, 8'h00, {7'h00, touchBusy_q});
         penDownPin <= 1'b0;
         $display("test pen done");
      end
   endtask
   task wtick;
      begin
         g = 1;
         @(negedge clk_sys);
         while (intervalTick_q !== 1'b1 && g < 100) begin
            @(negedge clk_sys);
            g = g + 1;
         end
      end
   endtask
   task t_tick(input [7:0] ctl, input [7:0] gap);
      begin
         wr(8'h70, ctl);
         repeat (3) wtick;
         chk("tickgap", ctl, gap, g[7:0]);
         $display("test interval %h done", ctl);
      end
   endtask
   initial begin
      repeat (2) @(posedge clk_sys);
      rst_b <= 1'b1;
      t_regs;
      t_results;
      aatr_adc_model_inst.lat = 9;
      seq(8'h01, 40'h18_2848_1828, 10);
      aatr_adc_model_inst.lat = 2;
      seq(8'h05, 40'h18_0000_0000, 2);
      seq(8'h04, 40'h00_0000_0000, 0);
      t_pen;
      t_tick(8'h08, 8'h05);
      t_tick(8'h00, 8'h14);
      complete_run;
   end
   initial begin
      repeat (20000) @(posedge clk_sys);
      errors = errors + 1;
      complete_run;
   end
endmodule // adc_auto_threshold_tsi_regs_tb_top
